// ---- rtl/sps_consts.svh ----
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define SPS_OFF_STAT 8'h00
`define SPS_OFF_CTL1 8'h04
`define SPS_OFF_CTL2 8'h08
`define SPS_OFF_DATA 8'h0c
`define SPS_OFF_ISTAT 8'h10
`define SPS_OFF_IMASK 8'h14
// ****************************************
// Field positions
// ****************************************
`define SPS_B_PORT_ON 15
`define SPS_B_HALT_IDLE 13
`define SPS_B_SHIFT_EMPTY 7
`define SPS_B_RX_OVF 6
`define SPS_B_RX_EMPTY 5
`define SPS_B_TX_FULL 1
`define SPS_B_RX_FULL 0
`define SPS_B_SAMPLE 9
`define SPS_B_SEL_EN 7
`define SPS_B_IDLE_POL 6
`define SPS_B_MASTER 5
`define SPS_B_FRAMED 15
`define SPS_B_SYNC_POL 13
// Interrupt status and mask bits
`define SPS_I_TX_EMPTY 0
`define SPS_I_RX_FULL 1
`define SPS_I_RX_OVF 2
`define SPS_I_CFG_ERR 3
// ****************************************
// Reset values and timing
// ****************************************
`define SPS_RST_HREADY 1'b1
`define SPS_WORD_BITS 16
`define SPS_CLK_NS 10
`define SPS_SCK_HALF_NS 40
`define SPS_SCK_HALF_CYC ((`SPS_SCK_HALF_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)
`endif

// ---- rtl/sps_pkg.sv ----
`default_nettype none
package sps_pkg;
   // ****************************************
   // Types
   // ****************************************
   // Port configuration seen by the shift engine
   typedef struct packed {
      logic framed;
      logic sync_pol;
      logic master;
      logic sample_late;
      logic sel_en;
      logic idle_pol;
   } sps_cfg_type;
   // Edge events and sampled pins toward the shift engine
   typedef struct packed {
      logic lead;
      logic trail;
      logic sdi;
      logic sel;
      logic sync;
   } sps_link_type;
   // Latched bus address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } sps_req_type;
   // Software visible state
   typedef struct packed {
      logic port_on;
      logic halt_idle;
      logic [2:0] irq_sel;
      logic rx_ovf;
      logic tx_full;
      logic rx_full;
      sps_cfg_type cfg;
      logic [15:0] tx_hold;
      logic [15:0] rx_buf;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
   } sps_regs_type;
   // Shift engine states
   typedef enum logic [1:0] {SPS_IDLE, SPS_LOADED, SPS_SHIFT} sps_state_type;
endpackage : sps_pkg
`default_nettype wire

// ---- rtl/sps_shifter.sv ----
`include "sps_consts.svh"
`default_nettype none
module sps_shifter (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic en,
   input wire sps_pkg::sps_cfg_type cfg,
   input wire sps_pkg::sps_link_type link,
   input wire logic start,
   input wire logic tx_full,
   input wire logic [15:0] tx_word,
   output logic load_ack,
   output logic armed,
   output logic busy,
   output logic sdo,
   output logic done,
   output logic [15:0] rx_word
);
   import sps_pkg::*;
   sps_state_type state, next_state; // Engine state
   logic [15:0] txs, next_txs; // Outgoing shift register
   logic [15:0] rxs, next_rxs; // Incoming shift register
   logic [4:0] cnt, next_cnt; // Bits sampled this word
   logic sample_ev; // Edge on which data is taken
   logic sample_ok; // Sample edge that counts
   logic frame_ok; // Slave may begin a word

   // ****************************************
   // Event decode
   // ****************************************
   // Framed mode wins if software also enabled the select pin
   always_comb begin
      sample_ev = (cfg.master && cfg.sample_late) ? link.trail : link.lead;
      sample_ok = sample_ev && (cfg.master || cfg.framed || !cfg.sel_en || link.sel);
      frame_ok = cfg.framed ? link.sync : (cfg.sel_en ? link.sel : 1'b1);
      load_ack = en && (state == SPS_IDLE) && tx_full;
      armed = (state == SPS_LOADED);
      busy = (state == SPS_SHIFT);
      done = en && busy && sample_ok && (cnt == 5'(`SPS_WORD_BITS - 1));
      rx_word = {rxs[14:0], link.sdi};
      sdo = txs[15];
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_state = state;
      next_txs = txs;
      next_rxs = rxs;
      next_cnt = cnt;
      case (state)
         SPS_IDLE, SPS_LOADED: begin
            // Holding word moves into the shifter
            if (load_ack) begin
               next_txs = tx_word;
               next_state = SPS_LOADED;
            end
            if (cfg.master) begin
               // Master waits for its own start slot
               if (armed && start) begin
                  next_state = SPS_SHIFT;
                  next_cnt = '0;
               end
            end else if (sample_ok && frame_ok) begin
               // Slave starts on any counted sample edge in frame, loaded or not
               next_rxs = {rxs[14:0], link.sdi};
               next_cnt = 5'd1;
               next_state = SPS_SHIFT;
            end
         end
         SPS_SHIFT: begin
            // Every counted edge advances the bit position
            if (sample_ok) begin
               next_rxs = {rxs[14:0], link.sdi};
               next_cnt = cnt + 5'd1;
            end
            if (done) begin
               next_state = SPS_IDLE;
               next_cnt = '0;
            end
            if (link.trail) begin
               next_txs = {txs[14:0], 1'b0};
            end
         end
         default: begin
            next_state = SPS_IDLE;
         end
      endcase
      // Port off holds the engine idle
      if (!en) begin
         next_state = SPS_IDLE;
         next_cnt = '0;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= SPS_IDLE;
         txs <= '0;
         rxs <= '0;
         cnt <= '0;
      end else begin
         state <= next_state;
         txs <= next_txs;
         rxs <= next_rxs;
         cnt <= next_cnt;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // A slave edge in the load cycle starts the word at once
   a_load_moves_word: assert property (load_ack |=> (txs == $past(tx_word)) && (armed || busy))
      else $error("Transmit word not moved into shifter");
   a_slave_edge_count: assert property (busy && en && !cfg.master && sample_ok && !done |=>
      cnt == $past(cnt) + 5'd1)
      else $error("Slave skipped a clock edge");
endmodule : sps_shifter
`default_nettype wire

// ---- rtl/sps_top.sv ----
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`include "sps_consts.svh"
`default_nettype none
// Contract
// - Framed: continuous clock, sync pulse starts frame
// - Sample phase settable only with master enable
// - Transfer start moves holding word into shifter; here an idle shifter takes it as soon as transmit is full
// - Non-framed slave shifts on every clock edge; here, with select enabled, edges while select is released are not counted
// - Data write sets transmit full
// - Move into shifter clears transmit full
module sps_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic sdi,
   output logic sdo_out,
   output logic sdo_oe,
   input wire logic ss_in,
   output logic ss_out,
   output logic ss_oe,
   output logic irq
);
   import sps_pkg::*;
   sps_req_type req, next_req; // Pending data phase
   logic [31:0] next_hrdata; // Read data for next phase
   logic [31:0] rd_word; // Decoded register value
   logic accept; // Address phase taken
   logic wr; // Write data phase now
   logic rd_clear; // Read of the data register
   sps_regs_type regs, next_regs; // Register file
   logic [3:0] ev; // Hardware events this cycle
   logic next_irq; // Interrupt level
   logic [2:0] sync1, sync2, sync3; // Pins: sck, sdi, ss
   logic [7:0] hcnt, next_hcnt; // Half period counter
   logic next_sck; // Master clock level
   logic msync, next_msync; // Master sync pulse
   logic run, tick, m_lead, m_trail, s_lead, s_trail; // Clock edges
   logic next_sck_oe, next_sdo_oe, next_ss_out, next_ss_oe; // Pin drive
   sps_link_type link; // Edges toward the engine
   logic start, load_ack, armed, busy, sdo, done; // Engine handshake
   logic [15:0] rx_word; // Received word
   logic [7:0] still, next_still; // Cycles without sck change

   // ****************************************
   // Bus slave
   // ****************************************
   // Zero wait: reads are fetched during the address phase
   always_comb begin
      accept = hsel && htrans[1] && hready;
      next_req.valid = accept;
      next_req.write = hwrite;
      next_req.addr = haddr[7:0];
      next_hrdata = (accept && !hwrite) ? rd_word : hrdata;
      rd_clear = accept && !hwrite && (haddr[7:0] == `SPS_OFF_DATA);
      wr = req.valid && req.write;
   end

   // Read decode; unmapped offsets read zero
   always_comb begin
      rd_word = 32'h0;
      case (haddr[7:0])
         `SPS_OFF_STAT: begin
            rd_word[`SPS_B_PORT_ON] = regs.port_on;
            rd_word[`SPS_B_HALT_IDLE] = regs.halt_idle;
            rd_word[10:8] = {2'h0, regs.tx_full};
            rd_word[`SPS_B_SHIFT_EMPTY] = !busy;
            rd_word[`SPS_B_RX_OVF] = regs.rx_ovf;
            rd_word[`SPS_B_RX_EMPTY] = !regs.rx_full;
            rd_word[4:2] = regs.irq_sel;
            rd_word[`SPS_B_TX_FULL] = regs.tx_full;
            rd_word[`SPS_B_RX_FULL] = regs.rx_full;
         end
         `SPS_OFF_CTL1: begin
            rd_word[`SPS_B_SAMPLE] = regs.cfg.sample_late;
            rd_word[`SPS_B_SEL_EN] = regs.cfg.sel_en;
            rd_word[`SPS_B_IDLE_POL] = regs.cfg.idle_pol;
            rd_word[`SPS_B_MASTER] = regs.cfg.master;
         end
         `SPS_OFF_CTL2: begin
            rd_word[`SPS_B_FRAMED] = regs.cfg.framed;
            rd_word[`SPS_B_SYNC_POL] = regs.cfg.sync_pol;
         end
         `SPS_OFF_DATA: begin
            rd_word[15:0] = regs.rx_buf;
         end
         `SPS_OFF_ISTAT: begin
            rd_word[3:0] = regs.irq_stat;
         end
         `SPS_OFF_IMASK: begin
            rd_word[3:0] = regs.irq_mask;
         end
         default: begin
            rd_word = 32'h0;
         end
      endcase
   end

   // Bus registers; response is always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req <= '0;
         hrdata <= 32'h0;
         hreadyout <= `SPS_RST_HREADY;
         hresp <= 1'b0;
      end else begin
         req <= next_req;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ****************************************
   // Register file and interrupts
   // ****************************************
   // Order: hardware clears, software writes, hardware sets
   always_comb begin
      next_regs = regs;
      ev = '0;
      if (load_ack) begin
         next_regs.tx_full = 1'b0;
      end
      if (rd_clear) begin
         next_regs.rx_full = 1'b0;
      end
      if (wr) begin
         case (req.addr)
            `SPS_OFF_STAT: begin
               next_regs.port_on = hwdata[`SPS_B_PORT_ON];
               next_regs.halt_idle = hwdata[`SPS_B_HALT_IDLE];
               next_regs.irq_sel = hwdata[4:2];
               // Overflow only clears by writing zero
               next_regs.rx_ovf = regs.rx_ovf && hwdata[`SPS_B_RX_OVF];
            end
            `SPS_OFF_CTL1: begin
               next_regs.cfg.master = hwdata[`SPS_B_MASTER];
               next_regs.cfg.sel_en = hwdata[`SPS_B_SEL_EN];
               next_regs.cfg.idle_pol = hwdata[`SPS_B_IDLE_POL];
               // Late sampling refused unless master is or becomes set
               next_regs.cfg.sample_late = hwdata[`SPS_B_SAMPLE] &&
                  (hwdata[`SPS_B_MASTER] || regs.cfg.master);
            end
            `SPS_OFF_CTL2: begin
               next_regs.cfg.framed = hwdata[`SPS_B_FRAMED];
               next_regs.cfg.sync_pol = hwdata[`SPS_B_SYNC_POL];
            end
            `SPS_OFF_DATA: begin
               next_regs.tx_hold = hwdata[15:0];
               next_regs.tx_full = 1'b1;
            end
            `SPS_OFF_ISTAT: begin
               next_regs.irq_stat = regs.irq_stat & ~hwdata[3:0];
            end
            `SPS_OFF_IMASK: begin
               next_regs.irq_mask = hwdata[3:0];
            end
            default: begin
               next_regs.irq_mask = regs.irq_mask;
            end
         endcase
      end
      // A finished word is dropped if the last one is unread
      if (done) begin
         if (next_regs.rx_full) begin
            next_regs.rx_ovf = 1'b1;
            ev[`SPS_I_RX_OVF] = 1'b1;
         end else begin
            next_regs.rx_buf = rx_word;
            next_regs.rx_full = 1'b1;
            ev[`SPS_I_RX_FULL] = 1'b1;
         end
      end
      ev[`SPS_I_TX_EMPTY] = load_ack;
      // Software set an illegal combination
      ev[`SPS_I_CFG_ERR] = regs.cfg.framed && regs.cfg.sel_en;
      next_regs.irq_stat = next_regs.irq_stat | ev;
      next_irq = |(regs.irq_stat & regs.irq_mask);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         regs <= '0;
         irq <= 1'b0;
      end else begin
         regs <= next_regs;
         irq <= next_irq;
      end
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Third stage only feeds edge detection from the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= 3'h7;
         sync2 <= 3'h7;
         sync3 <= 3'h7;
      end else begin
         sync1 <= {sck_in, sdi, ss_in};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // ****************************************
   // Master clock and sync
   // ****************************************
   // Framed master keeps the clock running between words
   always_comb begin
      run = regs.port_on && regs.cfg.master &&
         (regs.cfg.framed || busy || (sck_out != regs.cfg.idle_pol));
      tick = run && (hcnt == 8'(`SPS_SCK_HALF_CYC - 1));
      m_lead = tick && (sck_out == regs.cfg.idle_pol);
      m_trail = tick && (sck_out != regs.cfg.idle_pol);
      next_hcnt = (!run || tick) ? 8'h0 : hcnt + 8'h1;
      if (!regs.port_on || !regs.cfg.master) begin
         next_sck = regs.cfg.idle_pol;
      end else begin
         next_sck = tick ? !sck_out : sck_out;
      end
      // Framed words begin on a trailing edge with sync raised
      // Others wait for an idle clock, else the last trailing edge shifts the new word
      start = regs.cfg.framed ? m_trail : (sck_out == regs.cfg.idle_pol);
      next_msync = m_trail ? (armed && regs.cfg.framed) : msync;
      if (!regs.port_on || !regs.cfg.master) begin
         next_msync = 1'b0;
      end
      // Slave edges seen on the synchronised clock
      s_lead = (sync2[2] != sync3[2]) && (sync3[2] == regs.cfg.idle_pol);
      s_trail = (sync2[2] != sync3[2]) && (sync3[2] != regs.cfg.idle_pol);
      link.lead = regs.cfg.master ? m_lead : s_lead;
      link.trail = regs.cfg.master ? m_trail : s_trail;
      link.sdi = sync2[1];
      link.sel = !sync2[0];
      link.sync = (sync2[0] == regs.cfg.sync_pol);
      next_still = (!run || !regs.cfg.framed || (next_sck != sck_out)) ? 8'h0 : still + 8'h1;
   end

   // ****************************************
   // Pin drive
   // ****************************************
   // Pins belong to the port only while it is on
   always_comb begin
      next_sck_oe = regs.port_on && regs.cfg.master;
      next_sdo_oe = regs.port_on &&
         (regs.cfg.master || regs.cfg.framed || !regs.cfg.sel_en || link.sel);
      next_ss_oe = regs.port_on && regs.cfg.master && regs.cfg.framed;
      next_ss_out = next_msync ? regs.cfg.sync_pol : !regs.cfg.sync_pol;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hcnt <= 8'h0;
         sck_out <= 1'b0;
         msync <= 1'b0;
         still <= 8'h0;
         sck_oe <= 1'b0;
         sdo_oe <= 1'b0;
         sdo_out <= 1'b0;
         ss_oe <= 1'b0;
         ss_out <= 1'b1;
      end else begin
         hcnt <= next_hcnt;
         sck_out <= next_sck;
         msync <= next_msync;
         still <= next_still;
         sck_oe <= next_sck_oe;
         sdo_oe <= next_sdo_oe;
         sdo_out <= sdo;
         ss_oe <= next_ss_oe;
         ss_out <= next_ss_out;
      end
   end

   // ****************************************
   // Shift engine
   // ****************************************
   sps_shifter u_shift (
      .hclk(hclk),
      .hresetn(hresetn),
      .en(regs.port_on),
      .cfg(regs.cfg),
      .link(link),
      .start(start),
      .tx_full(regs.tx_full),
      .tx_word(regs.tx_hold),
      .load_ack(load_ack),
      .armed(armed),
      .busy(busy),
      .sdo(sdo),
      .done(done),
      .rx_word(rx_word)
   );

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_smp_refused: assert property (wr && (req.addr == `SPS_OFF_CTL1) && !hwdata[`SPS_B_MASTER] &&
      !regs.cfg.master |=> !regs.cfg.sample_late)
      else $error("Sample phase set without master");
   a_tx_full_set: assert property (wr && (req.addr == `SPS_OFF_DATA) |=> regs.tx_full)
      else $error("Data write did not set transmit full");
   a_tx_full_clear: assert property (load_ack && !(wr && (req.addr == `SPS_OFF_DATA)) |=>
      !regs.tx_full ##1 busy || armed)
      else $error("Transmit full not cleared on load");
   a_cfg_invalid: assert property (regs.cfg.framed && regs.cfg.sel_en |=>
      regs.irq_stat[`SPS_I_CFG_ERR])
      else $error("Invalid framing setup not flagged");
   a_port_off_pins: assert property (!regs.port_on |=> !sck_oe && !sdo_oe && !ss_oe)
      else $error("Pins driven while port off");
   a_framed_clock: assert property (still <= 8'(`SPS_SCK_HALF_CYC))
      else $error("Framed clock stopped");
   a_irq_level: assert property (##1 irq == $past(|(regs.irq_stat & regs.irq_mask)))
      else $error("Interrupt level mismatch");
   a_rx_overflow: assert property (done && regs.rx_full && !rd_clear |=> regs.rx_ovf &&
      regs.irq_stat[`SPS_I_RX_OVF])
      else $error("Overflow not flagged");
endmodule : sps_top
`default_nettype wire

// ---- tb/sps_far_model.sv ----
`default_nettype none
module sps_far_model (
   input wire logic sck_out,
   input wire logic sdo_out,
   output logic sck_in,
   output logic sdi,
   output logic ss_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Far serial party
   // ****************************************
   logic slave_role; // Set while acting as slave to our clock
   logic [15:0] tx_word; // Word handed back to the block
   logic [15:0] rx_word; // Word captured from the block
   int bit_idx; // Bits already sent as slave

   // Quiet lines at time zero, select released
   initial begin
      sck_in = 1'b0;
      sdi = 1'b0;
      ss_in = 1'b1;
      slave_role = 1'b0;
      bit_idx = 0;
      tx_word = 16'h0000;
      rx_word = 16'h0000;
   end

   // Preload before the master starts, else stale bits go out
   task load_slave(input logic [15:0] w);
      tx_word = w;
      bit_idx = 0;
      sdi = w[15];
      slave_role = 1'b1;
   endtask : load_slave

   // Capture on the leading edge of the block's clock
   always @(posedge sck_out) begin
      if (slave_role) begin
         rx_word = {rx_word[14:0], sdo_out};
      end
   end

   // Next bit on the trailing edge; line shows inverse once released
   always @(negedge sck_out) begin
      if (slave_role) begin
         bit_idx++;
         if (bit_idx < 16) begin
            sdi = tx_word[15 - bit_idx];
         end else begin
            sdi = ~sdi;
            slave_role = 1'b0;
         end
      end
   end

   // Act as master: clock only inside the frame, 80 ns period
   task send_master(input logic [16:0] v, input int n);
      ss_in = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sdi = v[i];
         #40 sck_in = 1'b1;
         #40 sck_in = 1'b0;
      end
      ss_in = 1'b1;
      sdi = ~sdi;
   endtask : send_master
endmodule : sps_far_model
`default_nettype wire

// ---- tb/tb.sv ----
`include "sps_consts.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Signals
   // ****************************************
   logic hclk, hresetn, hsel, hwrite; // Bus control
   logic [31:0] haddr, hwdata, hrdata; // Bus address and data
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire logic hready; // Single slave drives hready
   logic hreadyout, hresp, sck_out, sck_oe, sdo_out, sdo_oe, ss_out, ss_oe, irq;
   wire logic sck_in, sdi, ss_in; // Driven by the far party
   int mismatches, check_count;
   logic [31:0] rd; // Last read data
   logic s1, s2; // Clock samples

   // 100 MHz clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   assign hready = hreadyout;

   sps_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
      .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_in(ss_in), .ss_out(ss_out), .ss_oe(ss_oe),
      .irq(irq));
   sps_far_model far (.sck_out(sck_out), .sdo_out(sdo_out), .sck_in(sck_in), .sdi(sdi), .ss_in(ss_in));

   // ****************************************
   // Helpers
   // ****************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One single transfer; waits on hready, no fixed latency assumed
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : ahb

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h00000000);
      chk(rd, exp);
   endtask : rd_chk

   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up

   // ****************************************
   // Scenarios
   // ****************************************
   // Reset state, unmapped offset, pins released while off
   task t_reset;
      rd_chk(`SPS_OFF_STAT, 32'h000000a0);
      rd_chk(8'h18, 32'h00000000);
      chk({29'h0, sck_oe, sdo_oe, ss_oe}, 32'h0);
      chk({30'h0, irq, hresp}, 32'h0);
   endtask : t_reset

   // Sample phase refused without master enable
   task t_sample;
      ahb(1'b1, `SPS_OFF_CTL1, 32'h00000200);
      rd_chk(`SPS_OFF_CTL1, 32'h00000000);
      ahb(1'b1, `SPS_OFF_CTL1, 32'h00000220);
      rd_chk(`SPS_OFF_CTL1, 32'h00000220);
      ahb(1'b1, `SPS_OFF_CTL1, 32'h00000020);
   endtask : t_sample

   // Master word both ways, status flags and interrupt
   task t_master;
      ahb(1'b1, `SPS_OFF_IMASK, 32'h00000001);
      ahb(1'b1, `SPS_OFF_DATA, 32'h0000a55a);
      rd_chk(`SPS_OFF_STAT, 32'h000001a2);
      far.load_slave(16'h3c96);
      ahb(1'b1, `SPS_OFF_STAT, 32'h00008000);
      for (int k = 0; k < 600 && far.slave_role; k++) @(posedge hclk);
      chk({31'h0, sck_oe}, 32'h1);
      chk({16'h0, far.rx_word}, 32'h0000a55a);
      rd_chk(`SPS_OFF_STAT, 32'h00008081);
      chk({31'h0, irq}, 32'h1);
      ahb(1'b1, `SPS_OFF_IMASK, 32'h00000000);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      ahb(1'b1, `SPS_OFF_IMASK, 32'h00000001);
      ahb(1'b1, `SPS_OFF_ISTAT, 32'h0000000f);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      rd_chk(`SPS_OFF_DATA, 32'h00003c96);
   endtask : t_master

   // Invalid framed plus select flagged; framed clock keeps running
   task t_framed;
      ahb(1'b1, `SPS_OFF_CTL1, 32'h000000a0);
      ahb(1'b1, `SPS_OFF_CTL2, 32'h0000a000);
      ahb(1'b0, `SPS_OFF_ISTAT, 32'h00000000);
      chk(rd & 32'h8, 32'h8);
      ahb(1'b1, `SPS_OFF_DATA, 32'h00001234);
      for (int k = 0; k < 200 && ss_out !== 1'b1; k++) @(negedge hclk);
      chk({30'h0, ss_out, ss_oe}, 32'h3);
      repeat (300) @(negedge hclk);
      s1 = sck_out;
      repeat (4) @(negedge hclk);
      s2 = sck_out;
      chk({31'h0, s1 ^ s2}, 32'h1);
      ahb(1'b1, `SPS_OFF_CTL2, 32'h00000000);
      ahb(1'b1, `SPS_OFF_STAT, 32'h00000000);
      ahb(1'b1, `SPS_OFF_ISTAT, 32'h0000000f);
   endtask : t_framed

   // Slave without select: a spurious edge shifts the word by one
   task t_slave;
      ahb(1'b1, `SPS_OFF_CTL1, 32'h00000000);
      ahb(1'b1, `SPS_OFF_STAT, 32'h00008000);
      ahb(1'b0, `SPS_OFF_DATA, 32'h00000000);
      far.send_master(17'h1a5c3, 17);
      repeat (10) @(posedge hclk);
      rd_chk(`SPS_OFF_DATA, 32'h0000d2e1);
      // Leftover bit heads the next word; a further unread word overflows
      far.send_master(17'h00abc, 15);
      far.send_master(17'h0ffff, 16);
      repeat (10) @(posedge hclk);
      rd_chk(`SPS_OFF_DATA, 32'h00008abc);
      rd_chk(`SPS_OFF_STAT, 32'h000080e0);
   endtask : t_slave

   // ****************************************
   // Sequence and hang guard
   // ****************************************
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      mismatches = 0;
      check_count = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_sample;
      t_master;
      t_framed;
      t_slave;
      wrap_up;
   end

   // Whole run needs well under this many cycles
   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      wrap_up;
   end
endmodule : tb
`default_nettype wire
